// File: bbf_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module bbf_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 32
) (
	input  wire logic         clk_sys,   // System clock
	input  wire logic         rstn,      // Asynchronous reset, active low
	input  wire logic [W-1:0] in_data,   // Write data
	input  wire logic         in_valid,  // Write request
	output logic              in_ready,  // Space available
	output logic      [W-1:0] out_data,  // Head entry
	output logic              out_valid, // Head entry present
	input  wire logic         out_ready  // Head entry taken
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic          push;
	logic          pop;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rd_ptr_r];

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule : bbf_fifo

// File: bbf_framer.sv
// Binary block framer: wraps payloads into marked, checksummed, stuffed blocks
//
// What this block does
// - Every block opens with the start marker byte FE.
// - Every block closes with the end marker byte FF.
// - Byte FD is the escape prefix announcing an altered reserved value.
// - Stuffing touches only bytes between the markers; markers go out untouched.
// - Body bytes FD, FE, FF become FD 00, FD 01, FD 02.
// - An escape pair counts as one byte when bytes are counted.
// - Payload bytes may take any value from 00 to FF.
// - Most significant part goes first; multi-byte fields go high byte first.
// - The byte after the start marker is the block type identifier.
// - Two-byte length counts type, length and payload; payload is 1 to 1023.
// - Two-byte checksum, sum mod 65536 of type, length and payload, precedes end.
// - Numeric fields are fixed-point binary unless a field says otherwise.
// - Signed fields are two's complement unless a field says otherwise.
`timescale 1ns/1ps
module bbf_framer #(
	parameter int PAY_FIFO_DEPTH = bbf_pkg::FIFO_DEPTH
) (
	input  wire logic              clk_sys,     // System clock, 200 MHz
	input  wire logic              rstn,        // Asynchronous reset, active low
	input  wire bbf_pkg::bbf_req_s req,         // Block type and payload length
	input  wire logic              req_valid,   // Block request offered
	output logic                   req_ready,   // Block request taken
	input  wire bbf_pkg::bbf_byte_s pay_in,     // Payload byte with last flag
	input  wire logic              pay_valid,   // Payload byte offered
	output logic                   pay_ready,   // Payload byte taken
	output logic             [7:0] tx_byte,     // Line byte
	output logic                   tx_valid,    // Line byte present
	input  wire logic              tx_ready,    // Line byte taken
	output logic                   busy,        // Block in progress
	output logic                   req_err,     // Request refused, bad length
	output logic                   len_err,     // Last flag disagrees with length
	output logic             [7:0] blk_count,   // Blocks completed, wraps
	output logic            [15:0] last_cksum   // Checksum of the last block
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	bbf_pkg::bbf_state_e state_r;
	bbf_pkg::bbf_state_e state_nxt;
	bbf_pkg::bbf_byte_s  fifo_data;
	logic                fifo_valid;
	logic                fifo_ready;
	logic [7:0]          blk_type_r;
	logic [15:0]         len_r;
	logic [15:0]         pay_left_r;
	logic [15:0]         cksum_r;
	logic [15:0]         body_cnt_r;
	logic                last_seen_r;
	logic                req_err_r;
	logic                len_err_r;
	logic [7:0]          blk_count_r;
	logic [15:0]         last_cksum_r;
	logic [7:0]          st_byte;
	logic                st_body;
	logic                st_sum;
	logic                st_valid;
	logic                st_ready;
	logic                st_take;
	logic                req_take;
	logic                req_ok;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic len_in_range(input logic [15:0] n);
		len_in_range = (n >= bbf_pkg::PAY_MIN) && (n <= bbf_pkg::PAY_MAX);
	endfunction : len_in_range

	function automatic logic [15:0] add_byte(input logic [15:0] acc,
		input logic [7:0] b);
		// Carry out of bit 15 is dropped, giving the sum modulo 2^16
		add_byte = acc + {8'h00, b};
	endfunction : add_byte

	// ****************************************************************
	// Payload buffer
	// ****************************************************************
	// The producer may run ahead of the line by up to the FIFO depth;
	// once full, pay_ready drops and the producer is held off.
	bbf_fifo #(
		.W     ($bits(bbf_pkg::bbf_byte_s)),
		.DEPTH (PAY_FIFO_DEPTH)
	) u_pay_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_data   (pay_in),
		.in_valid  (pay_valid),
		.in_ready  (pay_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready)
	);

	// ****************************************************************
	// Escape stuffer on the line side
	// ****************************************************************
	bbf_stuffer u_stuffer (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_byte   (st_byte),
		.in_body   (st_body),
		.in_valid  (st_valid),
		.in_ready  (st_ready),
		.out_byte  (tx_byte),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	// ****************************************************************
	// Request acceptance
	// ****************************************************************
	assign req_ready = (state_r == bbf_pkg::ST_IDLE);
	assign req_take  = req_valid && req_ready;
	assign req_ok    = len_in_range(req.pay_len);

	// ****************************************************************
	// Raw byte selection for the stuffer
	// ****************************************************************
	always_comb
	begin
		st_byte  = 8'h00;
		st_body  = 1'b1;
		st_sum   = 1'b0;
		st_valid = 1'b0;
		case (state_r)
			bbf_pkg::ST_START:
			begin
				st_byte  = bbf_pkg::MARK_START;
				st_body  = 1'b0;
				st_valid = 1'b1;
			end
			bbf_pkg::ST_TYPE:
			begin
				st_byte  = blk_type_r;
				st_sum   = 1'b1;
				st_valid = 1'b1;
			end
			bbf_pkg::ST_LEN_HI:
			begin
				st_byte  = len_r[15:8];
				st_sum   = 1'b1;
				st_valid = 1'b1;
			end
			bbf_pkg::ST_LEN_LO:
			begin
				st_byte  = len_r[7:0];
				st_sum   = 1'b1;
				st_valid = 1'b1;
			end
			bbf_pkg::ST_PAYLOAD:
			begin
				// Payload is passed bit for bit; number formats are the producer's
				st_byte  = fifo_data.data;
				st_sum   = 1'b1;
				st_valid = fifo_valid;
			end
			bbf_pkg::ST_CK_HI:
			begin
				st_byte  = cksum_r[15:8];
				st_valid = 1'b1;
			end
			bbf_pkg::ST_CK_LO:
			begin
				st_byte  = cksum_r[7:0];
				st_valid = 1'b1;
			end
			bbf_pkg::ST_END:
			begin
				st_byte  = bbf_pkg::MARK_END;
				st_body  = 1'b0;
				st_valid = 1'b1;
			end
			default:
			begin
				st_byte  = 8'h00;
				st_valid = 1'b0;
			end
		endcase
	end

	assign st_take    = st_valid && st_ready;
	assign fifo_ready = (state_r == bbf_pkg::ST_PAYLOAD) && st_ready;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			bbf_pkg::ST_IDLE:
				if (req_take && req_ok)
					state_nxt = bbf_pkg::ST_START;
			bbf_pkg::ST_START:
				if (st_take)
					state_nxt = bbf_pkg::ST_TYPE;
			bbf_pkg::ST_TYPE:
				if (st_take)
					state_nxt = bbf_pkg::ST_LEN_HI;
			bbf_pkg::ST_LEN_HI:
				if (st_take)
					state_nxt = bbf_pkg::ST_LEN_LO;
			bbf_pkg::ST_LEN_LO:
				if (st_take)
					state_nxt = bbf_pkg::ST_PAYLOAD;
			bbf_pkg::ST_PAYLOAD:
				if (st_take && (pay_left_r == 16'h0001))
					state_nxt = bbf_pkg::ST_CK_HI;
			bbf_pkg::ST_CK_HI:
				if (st_take)
					state_nxt = bbf_pkg::ST_CK_LO;
			bbf_pkg::ST_CK_LO:
				if (st_take)
					state_nxt = bbf_pkg::ST_END;
			bbf_pkg::ST_END:
				if (st_take)
					state_nxt = bbf_pkg::ST_IDLE;
			default:
				state_nxt = bbf_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			state_r <= bbf_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// ****************************************************************
	// Block header capture
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			blk_type_r <= 8'h00;
			len_r      <= 16'h0000;
		end
		else if (req_take && req_ok)
		begin
			blk_type_r <= req.blk_type;
			len_r      <= req.pay_len + bbf_pkg::HDR_BYTES;
		end
	end

	// ****************************************************************
	// Payload countdown
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			pay_left_r <= 16'h0000;
		else if (req_take && req_ok)
			pay_left_r <= req.pay_len;
		else if ((state_r == bbf_pkg::ST_PAYLOAD) && st_take)
			pay_left_r <= pay_left_r - 16'h0001;
	end

	// ****************************************************************
	// Checksum and body count over unstuffed bytes
	// ****************************************************************
	// Both are taken on the raw byte before the stuffer, so an escape
	// pair on the line is summed and counted once.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			cksum_r <= bbf_pkg::CK_RESET;
		else if ((state_r == bbf_pkg::ST_START) && st_take)
			cksum_r <= bbf_pkg::CK_RESET;
		else if (st_take && st_sum)
			cksum_r <= add_byte(cksum_r, st_byte);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			body_cnt_r <= 16'h0000;
		else if ((state_r == bbf_pkg::ST_START) && st_take)
			body_cnt_r <= 16'h0000;
		else if (st_take && st_sum)
			body_cnt_r <= body_cnt_r + 16'h0001;
	end

	// ****************************************************************
	// Last flag agreement
	// ****************************************************************
	// The declared length wins: the framer always takes exactly that many
	// payload bytes, and a stray or missing last flag is only reported.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			last_seen_r <= 1'b0;
		else if ((state_r == bbf_pkg::ST_START) && st_take)
			last_seen_r <= 1'b0;
		else if ((state_r == bbf_pkg::ST_PAYLOAD) && st_take)
			last_seen_r <= fifo_data.last;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			len_err_r <= 1'b0;
		else if ((state_r == bbf_pkg::ST_PAYLOAD) && st_take)
			len_err_r <= fifo_data.last != (pay_left_r == 16'h0001);
		else if ((state_r == bbf_pkg::ST_CK_HI) && st_take)
			len_err_r <= (body_cnt_r != len_r) || !last_seen_r;
		else
			len_err_r <= 1'b0;
	end

	// ****************************************************************
	// Request refusal
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			req_err_r <= 1'b0;
		else
			req_err_r <= req_take && !req_ok;
	end

	// ****************************************************************
	// Status of finished blocks
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			blk_count_r  <= 8'h00;
			last_cksum_r <= bbf_pkg::CK_RESET;
		end
		else if ((state_r == bbf_pkg::ST_END) && st_take)
		begin
			blk_count_r  <= blk_count_r + 8'h01;
			last_cksum_r <= cksum_r;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign busy       = (state_r != bbf_pkg::ST_IDLE);
	assign req_err    = req_err_r;
	assign len_err    = len_err_r;
	assign blk_count  = blk_count_r;
	assign last_cksum = last_cksum_r;

endmodule : bbf_framer

// File: bbf_framer_chk.sv
// Concurrent checks on the framer's request and line ports
`timescale 1ns/1ps
module bbf_framer_chk #(
	parameter int PAY_FIFO_DEPTH = 32
) (
	input wire logic              clk_sys,   // Clock
	input wire logic              rstn,      // Reset, active low
	input wire bbf_pkg::bbf_req_s req,       // Request
	input wire logic              req_valid, // Request offered
	input wire logic              req_ready, // Request taken
	input wire logic        [7:0] tx_byte,   // Line byte
	input wire logic              tx_valid,  // Line byte present
	input wire logic              tx_ready,  // Line byte taken
	input wire logic              busy,      // Block in progress
	input wire logic              req_err,   // Refusal pulse
	input wire logic              len_err    // Length mismatch pulse
);
	// ****************
	// Line position
	// ****************
	logic [11:0] upos_r;
	logic        esc_r;
	logic  [7:0] type_r;
	logic [15:0] len_r;
	logic        len_ok;

	assign len_ok = req.pay_len >= bbf_pkg::PAY_MIN && req.pay_len <= bbf_pkg::PAY_MAX;

	function automatic logic [7:0] stf(input logic [7:0] b);
		return (b >= bbf_pkg::MARK_ESC) ? bbf_pkg::MARK_ESC : b;
	endfunction : stf

	// Prefix bytes hold the position, so field checks see unstuffed places
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			upos_r <= 12'h000;
			esc_r  <= 1'b0;
		end
		else if (tx_valid && tx_ready)
		begin
			upos_r <= (tx_byte == bbf_pkg::MARK_END) ? 12'h000 :
				(tx_byte == bbf_pkg::MARK_ESC) ? upos_r : upos_r + 12'h001;
			esc_r  <= tx_byte == bbf_pkg::MARK_ESC;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			type_r <= 8'h00;
			len_r  <= 16'h0000;
		end
		else if (req_valid && req_ready && len_ok)
		begin
			type_r <= req.blk_type;
			len_r  <= req.pay_len + bbf_pkg::HDR_BYTES;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// ****************
	// Assertions
	// ****************
	a_start_first: assert property (
		tx_valid && upos_r == 12'h000 |-> tx_byte == bbf_pkg::MARK_START)
		else $error("block does not open with the start marker");
	a_end_late: assert property (
		tx_valid && tx_byte == bbf_pkg::MARK_END |-> upos_r >= 12'h007)
		else $error("end marker before a whole block");
	a_mark_inside: assert property (
		tx_valid && upos_r != 12'h000 |-> tx_byte != bbf_pkg::MARK_START)
		else $error("start marker inside a block");
	a_esc_code: assert property (
		tx_valid && esc_r |-> tx_byte <= 8'h02)
		else $error("bad byte after escape prefix");
	a_type_next: assert property (
		tx_valid && upos_r == 12'h001 && !esc_r |-> tx_byte == stf(type_r))
		else $error("type byte wrong");
	a_len_high: assert property (
		tx_valid && upos_r == 12'h002 && !esc_r |-> tx_byte == stf(len_r[15:8]))
		else $error("length high byte wrong");
	a_len_low: assert property (
		tx_valid && upos_r == 12'h003 && !esc_r |-> tx_byte == stf(len_r[7:0]))
		else $error("length low byte wrong");
	a_req_accept: assert property (
		req_valid && req_ready && len_ok |=> busy && !req_ready)
		else $error("good request not started");
	a_req_refuse: assert property (
		req_valid && req_ready && !len_ok |=> req_err && !busy)
		else $error("bad length not refused");

	c_escape: cover property (tx_valid && tx_ready && esc_r);
	c_refuse: cover property (req_err);
	c_stall: cover property (tx_valid && !tx_ready);
	c_len_err: cover property (len_err);
endmodule : bbf_framer_chk

// File: bbf_host_model.sv
// Host-side deframer model for the framer's line output
`timescale 1ns/1ps
module bbf_host_model (
	input  wire logic       clk_sys,  // Clock
	input  wire logic       rstn,     // Reset, active low
	input  wire logic [7:0] tx_byte,  // Line byte
	input  wire logic       tx_valid, // Line byte present
	output logic            tx_ready, // Line byte taken
	input  wire logic       slow      // Stall three cycles in four
);
	// ****************
	// Receive and check
	// ****************
	logic  [7:0] line_q [$];
	logic  [7:0] u_q [$];
	logic        esc_r;
	logic  [1:0] cnt_r;
	logic [15:0] sum;
	int          blocks = 0;
	int          good = 0;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_r    <= 2'h0;
			tx_ready <= 1'b0;
		end
		else
		begin
			cnt_r    <= cnt_r + 2'h1;
			tx_ready <= !slow || cnt_r == 2'h0;
		end
	end

	// Counts every block in blocks; only one whose length and sum agree counts in good
	task automatic close_blk;
		int n;
		n = u_q.size();
		sum = bbf_pkg::CK_RESET;
		for (int i = 0; i < n - 2; i++)
			sum = sum + 16'(u_q[i]);
		if (n >= 5 && {u_q[1], u_q[2]} == 16'(n - 2)
				&& {u_q[n-2], u_q[n-1]} == sum)
			good++;
		blocks++;
	endtask : close_blk

	always @(posedge clk_sys)
	begin
		if (!rstn)
			esc_r = 1'b0;
		else if (tx_valid && tx_ready)
		begin
			line_q.push_back(tx_byte);
			if (tx_byte == bbf_pkg::MARK_START)
			begin
				u_q.delete();
				esc_r = 1'b0;
			end
			else if (tx_byte == bbf_pkg::MARK_END)
				close_blk();
			else if (esc_r)
			begin
				u_q.push_back(tx_byte + bbf_pkg::MARK_ESC);
				esc_r = 1'b0;
			end
			else if (tx_byte == bbf_pkg::MARK_ESC)
				esc_r = 1'b1;
			else
				u_q.push_back(tx_byte);
		end
	end
endmodule : bbf_host_model

// File: bbf_pkg.sv
// Shared constants, types and states of the binary block framer
package bbf_pkg;

	// ****************************************************************
	// Marker and escape bytes
	// ****************************************************************
	localparam logic [7:0]  MARK_START   = 8'hFE;
	localparam logic [7:0]  MARK_END     = 8'hFF;
	localparam logic [7:0]  MARK_ESC     = 8'hFD;

	// ****************************************************************
	// Field sizes and limits
	// ****************************************************************
	localparam int          LEN_W        = 16;
	localparam int          CK_W         = 16;
	localparam logic [15:0] HDR_BYTES    = 16'h0003;
	localparam logic [15:0] PAY_MIN      = 16'h0001;
	localparam logic [15:0] PAY_MAX      = 16'h03FF;
	localparam int          FIFO_DEPTH   = 32;
	localparam logic [15:0] CK_RESET     = 16'h0000;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [7:0]  blk_type;
		logic [15:0] pay_len;
	} bbf_req_s;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} bbf_byte_s;

	typedef enum logic [3:0] {
		ST_IDLE, ST_START, ST_TYPE, ST_LEN_HI, ST_LEN_LO,
		ST_PAYLOAD, ST_CK_HI, ST_CK_LO, ST_END
	} bbf_state_e;

endpackage : bbf_pkg

// File: bbf_stuffer.sv
// Escape stuffer: turns reserved body bytes into two-byte escape pairs
`timescale 1ns/1ps
module bbf_stuffer (
	input  wire logic       clk_sys,   // System clock
	input  wire logic       rstn,      // Asynchronous reset, active low
	input  wire logic [7:0] in_byte,   // Raw byte
	input  wire logic       in_body,   // Byte lies between the markers
	input  wire logic       in_valid,  // Raw byte offered
	output logic            in_ready,  // Raw byte taken
	output logic      [7:0] out_byte,  // Line byte
	output logic            out_valid, // Line byte present
	input  wire logic       out_ready  // Line byte taken
);
	logic [7:0] out_byte_r;
	logic       out_valid_r;
	logic [7:0] pend_byte_r;
	logic       pend_r;
	logic       advance;

	assign advance   = !out_valid_r || out_ready;
	// A pending second escape byte blocks new input for one slot
	assign in_ready  = advance && !pend_r;
	assign out_byte  = out_byte_r;
	assign out_valid = out_valid_r;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			out_byte_r  <= 8'h00;
			out_valid_r <= 1'b0;
			pend_byte_r <= 8'h00;
			pend_r      <= 1'b0;
		end
		else if (advance)
		begin
			if (pend_r)
			begin
				out_byte_r  <= pend_byte_r;
				out_valid_r <= 1'b1;
				pend_r      <= 1'b0;
			end
			else if (in_valid)
			begin
				out_valid_r <= 1'b1;
				if (in_body && (in_byte >= bbf_pkg::MARK_ESC))
				begin
					out_byte_r  <= bbf_pkg::MARK_ESC;
					pend_byte_r <= in_byte - bbf_pkg::MARK_ESC;
					pend_r      <= 1'b1;
				end
				else
					out_byte_r <= in_byte;
			end
			else
				out_valid_r <= 1'b0;
		end
	end

endmodule : bbf_stuffer

// File: test_binary_block_framer.sv
// Self-checking testbench for the binary block framer
`timescale 1ns/1ps
module test_binary_block_framer;
	// ****************
	// Signals
	// ****************
	logic               clk_sys = 1'b0;
	logic               rstn;
	bbf_pkg::bbf_req_s  req;
	logic               req_valid;
	logic               req_ready;
	bbf_pkg::bbf_byte_s pay_in;
	logic               pay_valid;
	logic               pay_ready;
	logic         [7:0] tx_byte;
	logic               tx_valid;
	logic               tx_ready;
	logic               busy;
	logic               req_err;
	logic               len_err;
	logic         [7:0] blk_count;
	logic        [15:0] last_cksum;
	logic               slow;
	logic         [7:0] nblk = 8'h00;
	logic         [7:0] pl [1024];
	logic         [7:0] exp_q [$];
	int                 err_count = 0;
	int                 checks_done = 0;
	int                 rerr_seen = 0;
	int                 lerr_seen = 0;

	always #2.5 clk_sys = ~clk_sys;

	bbf_framer dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .pay_in(pay_in), .pay_valid(pay_valid),
		.pay_ready(pay_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .busy(busy), .req_err(req_err), .len_err(len_err),
		.blk_count(blk_count), .last_cksum(last_cksum)
	);

	bbf_host_model host_u (
		.clk_sys(clk_sys), .rstn(rstn), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .slow(slow)
	);

	always @(posedge clk_sys)
	begin
		if (req_err === 1'b1)
			rerr_seen++;
		if (len_err === 1'b1)
			lerr_seen++;
	end

	// ****************
	// Shared tasks
	// ****************
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask : chk1

	task automatic hang;
		chk(16'h0000, 16'h0001);
		close_out();
	endtask : hang

	function automatic void put(input logic [7:0] b);
		if (b >= bbf_pkg::MARK_ESC)
		begin
			exp_q.push_back(bbf_pkg::MARK_ESC);
			exp_q.push_back(b - bbf_pkg::MARK_ESC);
		end
		else
			exp_q.push_back(b);
	endfunction : put

	task automatic send_req(input logic [7:0] t, input logic [15:0] n);
		int k;
		req       <= '{blk_type: t, pay_len: n};
		req_valid <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (req_ready !== 1'b1 && k < 5000);
		if (req_ready !== 1'b1)
			hang();
		req_valid <= 1'b0;
	endtask : send_req

	task automatic push(input logic [7:0] d, input logic l);
		int k;
		pay_in    <= '{data: d, last: l};
		pay_valid <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pay_ready !== 1'b1 && k < 20000);
		if (pay_ready !== 1'b1)
			hang();
	endtask : push

	// Bytes below pre are already in the buffer; lp is where last is flagged
	task automatic run_blk(input logic [7:0] t, input int n, input logic s, input int lp,
		input int pre);
		int b0;
		int g0;
		int st;
		logic [15:0] ln;
		logic [15:0] ck;
		ln = 16'(n) + bbf_pkg::HDR_BYTES;
		ck = 16'(t) + 16'(ln[15:8]) + 16'(ln[7:0]);
		exp_q = {bbf_pkg::MARK_START};
		put(t);
		put(ln[15:8]);
		put(ln[7:0]);
		for (int i = 0; i < n; i++)
		begin
			ck = ck + 16'(pl[i]);
			put(pl[i]);
		end
		put(ck[15:8]);
		put(ck[7:0]);
		exp_q.push_back(bbf_pkg::MARK_END);
		b0 = host_u.blocks;
		g0 = host_u.good;
		st = host_u.line_q.size();
		slow <= s;
		fork
			send_req(t, 16'(n));
			begin
				for (int i = pre; i < n; i++)
					push(pl[i], i == lp);
				pay_valid <= 1'b0;
			end
		join
		for (int k = 0; k < 20000 && host_u.blocks == b0; k++)
			@(posedge clk_sys);
		if (host_u.blocks == b0)
			hang();
		repeat (3) @(posedge clk_sys);
		nblk = nblk + 8'h01;
		chk(16'(host_u.line_q.size() - st), 16'(exp_q.size()));
		foreach (exp_q[i])
			chk(16'(host_u.line_q[st + i]), 16'(exp_q[i]));
		chk(16'(host_u.good - g0), 16'h0001);
		chk(16'(blk_count), 16'(nblk));
		chk(last_cksum, ck);
	endtask : run_blk

	// ****************
	// Scenarios
	// ****************
	task automatic t_plain;
		pl[0] = 8'h10;
		run_blk(8'h21, 1, 1'b0, 0, 0);
		$display("t_plain done");
	endtask : t_plain

	task automatic t_escape;
		logic [7:0] v [6] = '{8'hFD, 8'hFE, 8'hFF, 8'h00, 8'h7F, 8'h80};
		foreach (v[i])
			pl[i] = v[i];
		run_blk(8'hFE, 6, 1'b1, 5, 0);
		$display("t_escape done");
	endtask : t_escape

	task automatic t_all;
		for (int i = 0; i < 256; i++)
			pl[i] = 8'(i);
		run_blk(8'h7E, 256, 1'b0, 255, 0);
		$display("t_all done");
	endtask : t_all

	task automatic t_max;
		for (int i = 0; i < 1023; i++)
			pl[i] = 8'(i * 7 + 3);
		run_blk(8'hFF, 1023, 1'b1, 1022, 0);
		$display("t_max done");
	endtask : t_max

	task automatic t_fifo;
		for (int i = 0; i < 40; i++)
			pl[i] = 8'(8'hF0 + i);
		for (int i = 0; i < 32; i++)
			push(pl[i], 1'b0);
		pay_valid <= 1'b0;
		@(posedge clk_sys);
		chk1(pay_ready, 1'b0);
		run_blk(8'h33, 40, 1'b1, 39, 32);
		$display("t_fifo done");
	endtask : t_fifo

	task automatic t_len_err;
		int l0;
		pl[0] = 8'h01;
		pl[1] = 8'h02;
		pl[2] = 8'h03;
		l0 = lerr_seen;
		run_blk(8'h44, 3, 1'b0, 1, 0);
		chk1(lerr_seen != l0, 1'b1);
		$display("t_len_err done");
	endtask : t_len_err

	task automatic t_refuse;
		int r0;
		for (int j = 0; j < 2; j++)
		begin
			r0 = rerr_seen;
			send_req(8'h55, (j == 0) ? 16'h0000 : 16'h0400);
			repeat (3) @(posedge clk_sys);
			chk1(busy, 1'b0);
			chk(16'(rerr_seen - r0), 16'h0001);
			chk(16'(blk_count), 16'(nblk));
		end
		$display("t_refuse done");
	endtask : t_refuse

	initial
	begin
		rstn = 1'b0;
		req = '0;
		req_valid = 1'b0;
		pay_in = '0;
		pay_valid = 1'b0;
		slow = 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		chk1(req_ready, 1'b1);
		chk1(busy, 1'b0);
		chk(16'(blk_count), 16'h0000);
		t_plain();
		t_refuse();
		t_escape();
		t_all();
		t_fifo();
		t_len_err();
		t_max();
		close_out();
	end
endmodule : test_binary_block_framer

bind bbf_framer bbf_framer_chk #(.PAY_FIFO_DEPTH(PAY_FIFO_DEPTH)) chk_u (
	.clk_sys(clk_sys), .rstn(rstn), .req(req), .req_valid(req_valid),
	.req_ready(req_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .busy(busy), .req_err(req_err), .len_err(len_err)
);
